// file: design/viet_pkg.sv
// Overview of operation
// RULE_01 - Event pin is counter clock or external interrupt input, per status bit.
// RULE_02 - Falling event pin edge starts external interrupt when its enable is set.
// RULE_03 - Counter steps on machine clock tick or event pin, as selected.
// RULE_04 - Counter overflow starts counter interrupt when its enable is set.
// RULE_05 - Two request kinds, external and counter; one serviced at a time.
// RULE_06 - In-service latch blocks further interrupts; no nesting.
// RULE_07 - Pending bits visible; lone pending enabled request taken at once when idle.
// RULE_08 - External interrupt wins when both are pending and enabled.
// RULE_09 - External event during service sets new request, taken right after return.
// RULE_10 - External take pushes PC, vectors to octal 760, clears its request.
// RULE_11 - Counter request sets on 377 to 000 wrap; take vectors to octal 740.
// RULE_12 - Select one counts event pin falls; zero counts at oscillator/16 rate.
// RULE_13 - Only the interrupt return operation releases the in-service latch.
// RULE_14 - Event pin synchronised; exactly one event per falling edge.
// RULE_15 - Reset clears latch, both requests, both enables and count select.
package viet_pkg;
    localparam logic [10:0] VIET_EXT_VECTOR = 11'h1f0;
    localparam logic [10:0] VIET_CNT_VECTOR = 11'h1e0;
    localparam logic [7:0] VIET_CNT_MAX = 8'hff;
    localparam logic [7:0] VIET_CNT_RESET = 8'h00;
    localparam int VIET_OSC_DIV = 16;
    localparam int VIET_OSC_HZ = 4_000_000;
    localparam int VIET_REF_HZ = 50_000_000;
    localparam int VIET_TICK_CYCLES = (VIET_REF_HZ + (VIET_OSC_HZ / VIET_OSC_DIV) - 1)
        / (VIET_OSC_HZ / VIET_OSC_DIV);
    localparam logic [7:0] VIET_TICK_LAST = 8'(VIET_TICK_CYCLES - 1);

    typedef enum logic [2:0] {
        VIET_IDLE = 3'b001,
        VIET_EXT = 3'b010,
        VIET_CNT = 3'b100
    } viet_state_t;
endpackage : viet_pkg

// file: design/viet_evt_if.sv
interface viet_evt_if;
    logic fall;
    logic tick;
    modport src (output fall, output tick);
    modport dst (input fall, input tick);
endinterface : viet_evt_if

// file: design/viet_event_sync.sv
module viet_event_sync
    import viet_pkg::*;
(
    input wire logic ref_clk_i,
    input wire logic reset_n_i,
    input wire logic event_pin_n_i,
    viet_evt_if.src evt
);
    logic [2:0] sync_r;
    logic [2:0] sync_nxt;
    logic [7:0] div_r;
    logic [7:0] div_nxt;
    logic fall_r;
    logic fall_nxt;
    logic tick_r;
    logic tick_nxt;

    always_comb begin
        sync_nxt = {sync_r[1:0], event_pin_n_i};
        // Edge seen only between stages two and three
        fall_nxt = sync_r[2] & ~sync_r[1]; // RULE_14
        tick_nxt = (div_r == VIET_TICK_LAST); // RULE_12
        div_nxt = tick_nxt ? 8'h00 : div_r + 8'h01;
    end

    always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            sync_r <= 3'b111;
            div_r <= 8'h00;
            fall_r <= 1'b0;
            tick_r <= 1'b0;
        end else begin
            sync_r <= sync_nxt;
            div_r <= div_nxt;
            fall_r <= fall_nxt;
            tick_r <= tick_nxt;
        end
    end

    assign evt.fall = fall_r;
    assign evt.tick = tick_r;
endmodule : viet_event_sync

// file: design/viet_top.sv
module viet_top
    import viet_pkg::*;
(
    // Clock and reset
    input wire logic ref_clk_i,
    input wire logic reset_n_i,
    // Event pin
    input wire logic event_pin_n_i,
    // Status bit writes from the processor
    input wire logic status_we_i,
    input wire logic count_source_select_i,
    input wire logic counter_irq_request_i,
    input wire logic ext_irq_request_i,
    input wire logic counter_irq_enable_i,
    input wire logic ext_irq_enable_i,
    // Counter preset
    input wire logic counter_we_i,
    input wire logic [7:0] counter_data_i,
    // Control unit handshake
    input wire logic interrupt_return_op_i,
    input wire logic [10:0] pc_i,
    // Status view
    output logic count_source_select_o,
    output logic counter_irq_request_o,
    output logic ext_irq_request_o,
    output logic counter_irq_enable_o,
    output logic ext_irq_enable_o,
    output logic [7:0] event_counter_o,
    output logic in_service_o,
    // Interrupt take
    output logic take_o,
    output logic [10:0] vector_o,
    output logic [10:0] push_pc_o
);
    viet_evt_if evt ();

    viet_event_sync u_sync (
        .ref_clk_i(ref_clk_i),
        .reset_n_i(reset_n_i),
        .event_pin_n_i(event_pin_n_i),
        .evt(evt)
    );

    viet_state_t state_r;
    viet_state_t state_nxt;
    // Configuration bits
    logic sel_r;
    logic sel_nxt;
    logic cen_r;
    logic cen_nxt;
    logic xen_r;
    logic xen_nxt;
    // Request bits
    logic creq_r;
    logic creq_nxt;
    logic xreq_r;
    logic xreq_nxt;
    // Event counter
    logic [7:0] cnt_r;
    logic [7:0] cnt_nxt;
    // Service outputs
    logic take_r;
    logic take_nxt;
    logic busy_r;
    logic busy_nxt;
    logic [10:0] vec_r;
    logic [10:0] vec_nxt;
    logic [10:0] push_r;
    logic [10:0] push_nxt;
    // Decoded events and grants
    logic step;
    logic wrap;
    logic ext_evt;
    logic grant_ext;
    logic grant_cnt;

    // A request counts only while it is both set and enabled
    function automatic logic eligible(input logic req, input logic en);
        return req & en;
    endfunction : eligible

    always_comb begin
        // Pin feeds counter when selected, else interrupt path
        step = sel_r ? evt.fall : evt.tick; // RULE_01 RULE_03 RULE_12
        ext_evt = ~sel_r & evt.fall; // RULE_01 RULE_02
        // A preset in the same cycle hides the wrap
        wrap = step & (cnt_r == VIET_CNT_MAX) & ~counter_we_i; // RULE_11
    end

    always_comb begin
        // Software loads only; no hardware source
        sel_nxt = status_we_i ? count_source_select_i : sel_r;
        cen_nxt = status_we_i ? counter_irq_enable_i : cen_r;
        xen_nxt = status_we_i ? ext_irq_enable_i : xen_r;
    end

    always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin // RULE_15
            sel_r <= 1'b0;
            cen_r <= 1'b0;
            xen_r <= 1'b0;
        end else begin
            sel_r <= sel_nxt;
            cen_r <= cen_nxt;
            xen_r <= xen_nxt;
        end
    end

    always_comb begin
        // Preset beats a step in the same cycle
        if (counter_we_i) begin
            cnt_nxt = counter_data_i;
        end else if (step) begin
            // Wraps from full count to zero with no carry out
            cnt_nxt = cnt_r + 8'h01; // RULE_03
        end else begin
            cnt_nxt = cnt_r;
        end
    end

    always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            cnt_r <= VIET_CNT_RESET;
        end else begin
            cnt_r <= cnt_nxt;
        end
    end

    // Take decision; only the return brings the latch back to idle
    always_comb begin
        state_nxt = state_r;
        take_nxt = 1'b0;
        vec_nxt = vec_r;
        push_nxt = push_r;
        grant_ext = 1'b0;
        grant_cnt = 1'b0;
        case (state_r)
            VIET_IDLE: begin
                // External first when both are eligible
                if (eligible(xreq_r, xen_r)) begin // RULE_07 RULE_08
                    grant_ext = 1'b1;
                    state_nxt = VIET_EXT;
                    take_nxt = 1'b1;
                    vec_nxt = VIET_EXT_VECTOR; // RULE_10
                    // Address of the interrupted instruction goes to the stack
                    push_nxt = pc_i; // RULE_10
                end else if (eligible(creq_r, cen_r)) begin // RULE_04 RULE_07
                    grant_cnt = 1'b1;
                    state_nxt = VIET_CNT;
                    take_nxt = 1'b1;
                    vec_nxt = VIET_CNT_VECTOR; // RULE_11
                    push_nxt = pc_i; // RULE_11
                end
            end
            VIET_EXT, VIET_CNT: begin
                // Latch holds until the dedicated return; a plain return leaves it stuck
                if (interrupt_return_op_i) begin // RULE_13 RULE_06 RULE_05
                    state_nxt = VIET_IDLE;
                end
            end
            // Illegal one-hot codes fall back to idle
            default: state_nxt = VIET_IDLE;
        endcase
        // Registered so the status view comes straight from a flop
        busy_nxt = (state_nxt != VIET_IDLE); // RULE_06
    end

    always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin // RULE_15
            state_r <= VIET_IDLE;
            take_r <= 1'b0;
            busy_r <= 1'b0;
            vec_r <= 11'h000;
            push_r <= 11'h000;
        end else begin
            state_r <= state_nxt;
            take_r <= take_nxt;
            busy_r <= busy_nxt;
            vec_r <= vec_nxt;
            push_r <= push_nxt;
        end
    end

    always_comb begin
        // A status write may set or clear either request
        creq_nxt = status_we_i ? counter_irq_request_i : creq_r;
        xreq_nxt = status_we_i ? ext_irq_request_i : xreq_r;
        // Taking a request clears it at once
        if (grant_ext) begin
            xreq_nxt = 1'b0; // RULE_10
        end
        if (grant_cnt) begin
            creq_nxt = 1'b0; // RULE_11
        end
        // Hardware set wins over any clear, regardless of enable
        if (ext_evt) begin // RULE_02 RULE_09
            xreq_nxt = 1'b1;
        end
        if (wrap) begin // RULE_11 RULE_04
            creq_nxt = 1'b1;
        end
    end

    always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin // RULE_15
            creq_r <= 1'b0;
            xreq_r <= 1'b0;
        end else begin
            creq_r <= creq_nxt;
            xreq_r <= xreq_nxt;
        end
    end

    // Every output is a register
    assign count_source_select_o = sel_r;
    assign counter_irq_request_o = creq_r;
    assign ext_irq_request_o = xreq_r;
    assign counter_irq_enable_o = cen_r;
    assign ext_irq_enable_o = xen_r;
    assign event_counter_o = cnt_r;
    assign in_service_o = busy_r;
    assign take_o = take_r;
    assign vector_o = vec_r;
    assign push_pc_o = push_r;
endmodule : viet_top

// file: bench/viet_properties.sv
module viet_properties (
    input wire logic ref_clk_i,
    input wire logic reset_n_i,
    input wire logic interrupt_return_op_i,
    input wire logic counter_irq_request_o,
    input wire logic ext_irq_request_o,
    input wire logic counter_irq_enable_o,
    input wire logic ext_irq_enable_o,
    input wire logic in_service_o,
    input wire logic take_o,
    input wire logic [10:0] vector_o
);
    timeunit 1ns / 1ns;
    default clocking @(posedge ref_clk_i); endclocking
    default disable iff (!reset_n_i);
    sequence ext_rdy; ext_irq_request_o && ext_irq_enable_o && !in_service_o; endsequence
    sequence cnt_rdy; counter_irq_request_o && counter_irq_enable_o && !in_service_o; endsequence
    a_ext_first: assert property (ext_rdy |=> take_o && vector_o == 11'h1f0) else $error("ext");
    a_cnt_take: assert property (cnt_rdy ##0 !(ext_irq_request_o && ext_irq_enable_o)
        |=> take_o && vector_o == 11'h1e0) else $error("cnt");
    a_take_pulse: assert property (take_o |=> !take_o) else $error("pulse");
    a_no_nesting: assert property (take_o |-> in_service_o && !$past(in_service_o))
        else $error("nest");
    a_req_clear: assert property (take_o && vector_o == 11'h1f0 |-> !ext_irq_request_o)
        else $error("clear");
    a_ret_release: assert property (in_service_o && interrupt_return_op_i |=> !in_service_o)
        else $error("release");
    a_serv_holds: assert property (in_service_o && !interrupt_return_op_i |=> in_service_o)
        else $error("hold");
    a_vec_holds: assert property (!take_o |=> take_o || $stable(vector_o)) else $error("vec");
endmodule : viet_properties
bind viet_top viet_properties PROPS (.*);

// file: bench/viet_event_src.sv
module viet_event_src (
    input wire logic ref_clk_i,
    input wire logic fire_i,
    output logic event_pin_n_o = 1'h1
);
    timeunit 1ns / 1ns;
    // Low for three cycles so the synchroniser sees exactly one fall
    always @(posedge fire_i) begin
        event_pin_n_o = 1'h0;
        repeat (3) @(negedge ref_clk_i);
        event_pin_n_o = 1'h1;
    end
endmodule : viet_event_src

// file: bench/viet_top_bench.sv
module viet_top_bench;
    timeunit 1ns / 1ns;
    logic clk = 1'h0, rst_n = 1'h0, fire = 1'h0, swe = 1'h0, cwe = 1'h0, ret = 1'h0;
    // Select, counter request, external request, counter enable, external enable
    logic [4:0] st = 5'h00;
    logic [7:0] cd = 8'hff;
    logic [10:0] pc = 11'h000;
    wire pin_n;
    wire [6:0] fl;
    wire [10:0] vec, push;
    wire [7:0] cnt;
    int failures = 0, comparisons = 0;
    always #10 clk = ~clk;
    viet_event_src SRC (.ref_clk_i(clk), .fire_i(fire), .event_pin_n_o(pin_n));
    viet_top DUT (.ref_clk_i(clk), .reset_n_i(rst_n), .event_pin_n_i(pin_n), .status_we_i(swe),
        .count_source_select_i(st[4]), .counter_irq_request_i(st[3]), .ext_irq_request_i(st[2]),
        .counter_irq_enable_i(st[1]), .ext_irq_enable_i(st[0]), .counter_we_i(cwe), .counter_data_i(cd),
        .interrupt_return_op_i(ret), .pc_i(pc), .count_source_select_o(fl[4]), .counter_irq_request_o(fl[3]),
        .ext_irq_request_o(fl[2]), .counter_irq_enable_o(fl[1]), .ext_irq_enable_o(fl[0]),
        .event_counter_o(cnt), .in_service_o(fl[5]), .take_o(fl[6]), .vector_o(vec), .push_pc_o(push));
    task automatic chk(input logic [10:0] exp, input logic [10:0] got);
        comparisons++;
        if (got !== exp) failures++;
        if (got !== exp) $display("FAIL %0t mismatch %h", $time, got);
    endtask : chk
    task automatic chk_cnt(input logic [7:0] exp);
        comparisons++;
        if (cnt !== exp) begin
            failures++;
            $display("FAIL %0t counter %h", $time, cnt);
        end
    endtask : chk_cnt
    function automatic logic [7:0] count_after(input logic [7:0] start, input int steps);
        return 8'(int'(start) + steps);
    endfunction : count_after
    function automatic logic wrapped(input logic [7:0] start, input int steps);
        return (int'(start) + steps) > 255;
    endfunction : wrapped
    task automatic pulse(ref logic s);
        s = 1'h1;
        @(negedge clk);
        s = 1'h0;
        @(negedge clk);
    endtask : pulse
    // Leaves the pin high long enough for the next fall to be seen on its own
    task automatic fire_evt;
        pulse(fire);
        repeat (3) @(negedge clk);
    endtask : fire_evt
    task automatic take(input logic [10:0] want);
        repeat (20) if (fl[6] !== 1'h1) @(negedge clk);
        chk(want, fl[6] === 1'h1 ? vec : 11'h7ff);
        chk(pc, push);
    endtask : take
    task automatic complete_run;
        $display("comparisons %0d failures %0d", comparisons, failures);
        if (failures == 0 && comparisons > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask : complete_run
    initial begin
        // About four times the cycles the tests need
        repeat (2000) @(posedge clk);
        failures++;
        complete_run();
    end
    initial begin
        logic [7:0] start;
        int steps;
        pc = 11'($urandom(32'hc78b));
        #40 rst_n = 1'h1;
        @(negedge clk);
        chk(11'h000, {4'h0, fl});
        st = 5'h01;
        pulse(swe);
        pulse(fire);
        take(11'h1f0);
        pulse(fire);
        repeat (8) @(negedge clk);
        chk(11'h025, {4'h0, fl});
        pulse(ret);
        take(11'h1f0);
        pulse(ret);
        $display("external test done");
        st = 5'h14;
        pulse(swe);
        pulse(cwe);
        pulse(fire);
        repeat (6) @(negedge clk);
        chk(11'h01c, {4'h0, fl});
        chk_cnt(8'h00);
        st = 5'h1f;
        pulse(swe);
        take(11'h1f0);
        pulse(ret);
        take(11'h1e0);
        pulse(ret);
        $display("counter test done");
        st = 5'h10;
        repeat (4) begin
            start = 8'hfa + 8'($urandom % 6);
            steps = 1 + int'($urandom % 6);
            cd = start;
            pulse(swe);
            pulse(cwe);
            repeat (steps) fire_evt();
            chk_cnt(count_after(start, steps));
            chk(wrapped(start, steps) ? 11'h018 : 11'h010, {4'h0, fl});
        end
        $display("random count test done");
        st = 5'h00;
        cd = 8'hff;
        pulse(cwe);
        pulse(swe);
        repeat (viet_pkg::VIET_TICK_CYCLES - 1) @(negedge clk);
        chk_cnt(8'h00);
        chk(11'h008, {4'h0, fl});
        repeat (viet_pkg::VIET_TICK_CYCLES) @(negedge clk);
        chk_cnt(8'h01);
        $display("tick test done");
        st = 5'h1f;
        pulse(swe);
        rst_n = 1'h0;
        repeat (2) @(negedge clk);
        rst_n = 1'h1;
        @(negedge clk);
        chk(11'h000, {4'h0, fl});
        chk_cnt(8'h00);
        $display("reset test done");
        complete_run();
    end
endmodule : viet_top_bench
